// ---- hw/ref_switch_consts.svh ----
// constants for the reference clock switchover controller and its control end
//
// Overview of operation
// - override mode accepts switch requests, any frequencies
// - software switches manually when frequencies differ >20%
// - rising request gates output at current falling edge
// - mux moves at target falling edge, indicator follows
// - override: indicator follows the request level; the code instead toggles it on each completed switch
// - no lost flag while both inputs toggle
// - only rising request edges start a switchover
// - switch completes only once target input toggles
// - manual mode: primary by default, request decides
// - request must rise, then hold three cycles
// - request returns low before another switch
// - hold request three cycles of slower input
// - gate off, switch, wait, then re-enable; the code switches and re-enables on the same target fall
// - stalled current clock keeps selection, no transition
// - lost flag about two cycles after last edge
// - request held high blocks automatic switchover
`ifndef REF_SWITCH_CONSTS_SVH
`define REF_SWITCH_CONSTS_SVH

// ======================================================
// clock and timing
`define PCLK_PERIOD_NS 4
`define SENSE_WIDTH 16
`define SENSE_MAX 16'hFFFF
`define MIN_HOLD_REF_CYCLES 2'h3
`define REQ_MIN_HOLD_NS 1000
`define REQ_MIN_HOLD_CYCLES ((`REQ_MIN_HOLD_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define HOLD_CNT_WIDTH 10

// ======================================================
// controller register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0C

// ======================================================
// field positions
`define CTRL_REQ_BIT 0
`define CTRL_AUTO_BIT 1
`define ST_SEL_BIT 0
`define ST_PLOST_BIT 1
`define ST_BLOST_BIT 2
`define EV_SWITCH_BIT 0
`define EV_PLOST_BIT 1
`define EV_BLOST_BIT 2

// ======================================================
// reset values
`define CTRL_RESET 2'h0
`define IRQ_MASK_RESET 3'h0

`endif

// ---- hw/ref_switch_pkg.sv ----
// types shared by both ends of the reference switchover link
package ref_switch_pkg;

    // ======================================================
    // switchover sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_GATE = 4'b0100,
        ST_MOVE = 4'b1000
    } sw_state_e;

    typedef logic [2:0] event_t;

endpackage : ref_switch_pkg

// ---- hw/ref_switch_if.sv ----
// link between the switchover device and its fabric control logic
`timescale 1ns/1ps
`default_nettype none

interface ref_switch_if;
    logic switch_request;
    logic auto_mode;
    logic selected_input;
    logic primary_lost;
    logic backup_lost;

    modport device (
        input switch_request,
        input auto_mode,
        output selected_input,
        output primary_lost,
        output backup_lost
    );

    modport controller (
        output switch_request,
        output auto_mode,
        input selected_input,
        input primary_lost,
        input backup_lost
    );
endinterface : ref_switch_if

`default_nettype wire

// ---- hw/ref_clock_switchover.sv ----
// glitch-free reference clock switchover with clock sensing
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ref_switch_consts.svh"

module ref_clock_switchover (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // reference inputs, sampled on pclk
    input wire logic primary_ref_input,
    input wire logic backup_ref_input,
    // gated reference towards the pll
    output logic ref_out,
    // control link
    ref_switch_if.device link
);
    import ref_switch_pkg::*;

    // ======================================================
    // declarations
    logic req_s1;
    logic req_s2;
    logic req_prev;
    logic req_rise;
    logic [1:0] ref_q;
    logic [1:0] ref_q2;
    logic [1:0] ref_rise;
    logic [1:0] ref_fall;
    logic [1:0] lost;
    logic sel;
    logic gated;
    logic [1:0] cnt_p;
    logic [1:0] cnt_b;
    sw_state_e state;
    logic cur_fall;
    logic oth_fall;
    logic cur_lost;
    logic oth_lost;
    logic hold_done;

    // ======================================================
    // request synchroniser, first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_prev <= 1'b0;
        end else begin
            req_s1 <= link.switch_request;
            req_s2 <= req_s1;
            req_prev <= req_s2;
        end
    end

    // only a low-to-high change of the request counts
    assign req_rise = req_s2 & ~req_prev;

    // ======================================================
    // input sampling and edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 2'h0;
            ref_q2 <= 2'h0;
        end else begin
            ref_q <= {backup_ref_input, primary_ref_input};
            ref_q2 <= ref_q;
        end
    end

    assign ref_rise = ref_q & ~ref_q2;
    assign ref_fall = ~ref_q & ref_q2;

    // ======================================================
    // clock sense: one monitor per input
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sense
            logic [`SENSE_WIDTH-1:0] since;
            logic [`SENSE_WIDTH-1:0] period;
            logic seen;
            logic valid;

            // measures the period and counts cycles since the last rising edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    since <= '0;
                    period <= '0;
                    seen <= 1'b0;
                    valid <= 1'b0;
                end else if (ref_rise[gi]) begin
                    period <= (since == `SENSE_MAX) ? since : since + 16'h0001;
                    since <= '0;
                    seen <= 1'b1;
                    // the span from reset to the first edge is no period, so no false loss
                    valid <= seen;
                end else if (since != `SENSE_MAX) begin
                    since <= since + 16'h0001;
                end
            end

            // flags the input once two of its periods pass with no edge
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lost[gi] <= 1'b0;
                end else if (ref_rise[gi]) begin
                    lost[gi] <= 1'b0;
                end else begin
                    lost[gi] <= valid && ({1'b0, since} > {period, 1'b0});
                end
            end
        end
    endgenerate

    // ======================================================
    // current and target views
    assign cur_fall = sel ? ref_fall[1] : ref_fall[0];
    assign oth_fall = sel ? ref_fall[0] : ref_fall[1];
    assign cur_lost = sel ? lost[1] : lost[0];
    assign oth_lost = sel ? lost[0] : lost[1];
    assign hold_done = (cnt_p >= `MIN_HOLD_REF_CYCLES) && (cnt_b >= `MIN_HOLD_REF_CYCLES);

    // ======================================================
    // hold-time counters, rising edges of each input while armed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_p <= 2'h0;
            cnt_b <= 2'h0;
        end else if (state != ST_HOLD) begin
            cnt_p <= 2'h0;
            cnt_b <= 2'h0;
        end else begin
            if (ref_rise[0] && cnt_p != `MIN_HOLD_REF_CYCLES) begin
                cnt_p <= cnt_p + 2'h1;
            end
            if (ref_rise[1] && cnt_b != `MIN_HOLD_REF_CYCLES) begin
                cnt_b <= cnt_b + 2'h1;
            end
        end
    end

    // ======================================================
    // switchover sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (req_rise) begin
                        state <= ST_HOLD;
                    end else if (link.auto_mode && !req_s2 && cur_lost && !oth_lost) begin
                        state <= ST_MOVE;
                    end
                end
                ST_HOLD: begin
                    if (!req_s2) begin
                        state <= ST_IDLE;
                    end else if (hold_done) begin
                        state <= ST_GATE;
                    end
                end
                ST_GATE: begin
                    // a stalled current input never falls, so nothing moves
                    if (cur_fall) begin
                        state <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (oth_fall && !oth_lost) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // output gate: drops low while the mux is moved
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated <= 1'b0;
        end else if (state == ST_GATE && cur_fall) begin
            gated <= 1'b1;
        end else if (state == ST_IDLE && link.auto_mode && !req_s2 && !req_rise && cur_lost && !oth_lost) begin
            gated <= 1'b1;
        end else if (state == ST_MOVE && oth_fall && !oth_lost) begin
            gated <= 1'b0;
        end
    end

    // ======================================================
    // multiplexer select, primary after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= 1'b0;
        end else if (state == ST_MOVE && oth_fall && !oth_lost) begin
            sel <= ~sel;
        end
    end

    // ======================================================
    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_out <= 1'b0;
        end else begin
            ref_out <= !gated && (sel ? ref_q[1] : ref_q[0]);
        end
    end

    // indicator trails the mux by one cycle; each completed switch toggles it, whatever the request level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.selected_input <= 1'b0;
        end else begin
            link.selected_input <= sel;
        end
    end

    // lost flags towards the controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.primary_lost <= 1'b0;
            link.backup_lost <= 1'b0;
        end else begin
            link.primary_lost <= lost[0];
            link.backup_lost <= lost[1];
        end
    end

endmodule : ref_clock_switchover

`default_nettype wire

// ---- hw/switch_controller.sv ----
// fabric control end: apb registers, request driver and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ref_switch_consts.svh"

module switch_controller (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // link to the device
    ref_switch_if.controller link
);
    import ref_switch_pkg::*;

    // ======================================================
    // declarations
    logic [1:0] ctrl;
    logic [2:0] mask;
    event_t status;
    event_t events;
    logic sel_prev;
    logic plost_prev;
    logic blost_prev;
    logic [`HOLD_CNT_WIDTH-1:0] hold_cnt;
    logic access;
    logic wr;
    logic rd_stat;
    logic mapped;
    event_t kept;

    // a write or a read clear lands on the edge that completes the transfer
    assign access = psel && penable && !pready;
    assign wr = psel && penable && pready && pwrite;
    assign rd_stat = psel && penable && pready && !pwrite && (paddr == `REG_IRQ_STATUS);
    assign mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                    (paddr == `REG_IRQ_STATUS) || (paddr == `REG_IRQ_MASK);

    // ======================================================
    // apb answer: one wait state, registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= 32'h00000000;
            if (access && !pwrite) begin
                case (paddr)
                    `REG_CTRL: prdata <= {30'h0, ctrl};
                    `REG_STATUS: prdata <= {29'h0, link.backup_lost, link.primary_lost, link.selected_input};
                    `REG_IRQ_STATUS: prdata <= {29'h0, status};
                    `REG_IRQ_MASK: prdata <= {29'h0, mask};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ======================================================
    // control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CTRL_RESET;
            mask <= `IRQ_MASK_RESET;
        end else if (wr && paddr == `REG_CTRL) begin
            ctrl <= pwdata[1:0];
        end else if (wr && paddr == `REG_IRQ_MASK) begin
            mask <= pwdata[2:0];
        end
    end

    // ======================================================
    // request driver: a raised request stays up for the minimum hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.switch_request <= 1'b0;
            hold_cnt <= '0;
        end else if (ctrl[`CTRL_REQ_BIT] && !link.switch_request) begin
            link.switch_request <= 1'b1;
            hold_cnt <= `HOLD_CNT_WIDTH'(`REQ_MIN_HOLD_CYCLES);
        end else if (hold_cnt != '0) begin
            hold_cnt <= hold_cnt - `HOLD_CNT_WIDTH'(1);
        end else begin
            link.switch_request <= ctrl[`CTRL_REQ_BIT];
        end
    end

    // mode select towards the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.auto_mode <= 1'b0;
        end else begin
            link.auto_mode <= ctrl[`CTRL_AUTO_BIT];
        end
    end

    // ======================================================
    // event detection and sticky status, set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev <= 1'b0;
            plost_prev <= 1'b0;
            blost_prev <= 1'b0;
        end else begin
            sel_prev <= link.selected_input;
            plost_prev <= link.primary_lost;
            blost_prev <= link.backup_lost;
        end
    end

    assign events = {link.backup_lost & ~blost_prev, link.primary_lost & ~plost_prev,
                     link.selected_input ^ sel_prev};

    // a read clears only the bits it reported, so events after the capture survive
    assign kept = rd_stat ? (status & ~prdata[2:0]) : status;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 3'h0;
        end else begin
            status <= kept | events;
        end
    end

    // level interrupt from unmasked status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((kept | events) & mask);
        end
    end

endmodule : switch_controller

`default_nettype wire

// ---- sim/ref_switch_properties.sv ----
// concurrent checks on the switch link between device and control end
`timescale 1ns/1ps
`default_nettype none
`include "ref_switch_consts.svh"

module ref_switch_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link signals
    input wire logic switch_request,
    input wire logic auto_mode,
    input wire logic selected_input,
    input wire logic primary_lost,
    input wire logic backup_lost
);
    // ======================================================
    // helper logic
    logic [9:0] hold_cnt;
    logic [1:0] chg_cnt;
    logic cur_lost;
    logic auto_due;

    // lost flag of the input in use, and an automatic switch that is due
    assign cur_lost = selected_input ? backup_lost : primary_lost;
    assign auto_due = auto_mode && !switch_request && cur_lost && !(selected_input ? primary_lost : backup_lost);

    // length of the current request pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 10'h000;
        end else if (!switch_request) begin
            hold_cnt <= 10'h000;
        end else if (hold_cnt != 10'h3FF) begin
            hold_cnt <= hold_cnt + 10'h001;
        end
    end

    // selection changes during one request pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_cnt <= 2'h0;
        end else if (!switch_request) begin
            chg_cnt <= 2'h0;
        end else if ($changed(selected_input) && chg_cnt != 2'h3) begin
            chg_cnt <= chg_cnt + 2'h1;
        end
    end

    // ======================================================
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_reset_state;
        $rose(presetn) |-> !selected_input && !primary_lost && !backup_lost && !switch_request;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("link not idle after reset");

    property p_min_hold;
        $fell(switch_request) |-> hold_cnt >= `REQ_MIN_HOLD_CYCLES;
    endproperty
    a_min_hold: assert property (p_min_hold) else $error("request pulse too short");

    property p_sync_delay;
        $rose(switch_request) |-> $stable(selected_input) [*3];
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("selection moved before request synchronised");

    property p_one_per_rise;
        switch_request |-> chg_cnt < 2'h2;
    endproperty
    a_one_per_rise: assert property (p_one_per_rise) else $error("second switch within one request");

    property p_fall_keeps;
        (!auto_mode && !switch_request) [*4] |=> $stable(selected_input);
    endproperty
    a_fall_keeps: assert property (p_fall_keeps) else $error("selection moved with request low");

    property p_manual_by_request;
        !auto_mode && $changed(selected_input) |-> switch_request;
    endproperty
    a_manual_by_request: assert property (p_manual_by_request) else $error("manual mode switched unasked");

    property p_auto_bound;
        auto_due |-> ##[1:300] !auto_due;
    endproperty
    a_auto_bound: assert property (p_auto_bound) else $error("automatic switch did not complete");

    property p_auto_on_loss;
        auto_mode && !switch_request && $changed(selected_input) |-> $past(cur_lost);
    endproperty
    a_auto_on_loss: assert property (p_auto_on_loss) else $error("automatic switch from a live input");
endmodule : ref_switch_properties

`default_nettype wire

// ---- sim/tb_ref_clock_switchover.sv ----
// self-checking bench for the switchover device and its control end
`timescale 1ns/1ps
`default_nettype none
`include "ref_switch_consts.svh"

module tb_ref_clock_switchover;
    // ======================================================
    // bench signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ref_out;
    logic p_ref = 1'b0;
    logic b_ref = 1'b0;
    logic p_run = 1'b1;
    logic b_run = 1'b1;
    logic [1:0] p_hist = 2'h0;
    logic [1:0] b_hist = 2'h0;
    logic [31:0] rd;
    logic err;
    logic [2:0] mask;
    int p_half = 21;
    int b_half = 22;
    int p_cnt = 0;
    int b_cnt = 0;
    int seed = 24;
    int cycles = 0;
    int n_mismatch = 0;
    int check_count = 0;

    ref_switch_if link_if ();

    ref_clock_switchover ref_clock_switchover_inst (.pclk(pclk), .presetn(presetn), .primary_ref_input(p_ref),
        .backup_ref_input(b_ref), .ref_out(ref_out), .link(link_if));

    switch_controller switch_controller_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .link(link_if));

    ref_switch_properties ref_switch_properties_inst (.pclk(pclk), .presetn(presetn),
        .switch_request(link_if.switch_request), .auto_mode(link_if.auto_mode),
        .selected_input(link_if.selected_input), .primary_lost(link_if.primary_lost),
        .backup_lost(link_if.backup_lost));

    // clock and reference inputs; a stopped input rests low
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        p_cnt <= (!p_run || p_cnt >= p_half - 1) ? 0 : p_cnt + 1;
        p_ref <= !p_run ? 1'b0 : (p_cnt >= p_half - 1) ? ~p_ref : p_ref;
        b_cnt <= (!b_run || b_cnt >= b_half - 1) ? 0 : b_cnt + 1;
        b_ref <= !b_run ? 1'b0 : (b_cnt >= b_half - 1) ? ~b_ref : b_ref;
        p_hist <= {p_hist[0], p_ref};
        b_hist <= {b_hist[0], b_ref};
    end

    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ======================================================
    // tasks and expectations
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] st(input logic s, input logic pl, input logic bl);
        return {29'h0, bl, pl, s};
    endfunction : st

    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(n), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic wait_sel(input logic e, input int lim);
        int n;
        n = 0;
        while (link_if.selected_input !== e && n < lim) begin
            n++;
            @(posedge pclk);
        end
        chk({31'h0, link_if.selected_input}, {31'h0, e});
    endtask : wait_sel

    // reference output against the selected input, two clocks late
    task automatic chk_out(input logic s, input int n);
        repeat (n) begin
            @(posedge pclk);
            chk({31'h0, ref_out}, {31'h0, s ? b_hist[1] : p_hist[1]});
        end
    endtask : chk_out

    task automatic done(input string s);
        $display("test %s done at %0t", s, $time);
    endtask : done

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ======================================================
    // main sequence
    initial begin
        p_half = 21 + ($random(seed) & 1);
        b_half = 22 + ($random(seed) & 1);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`REG_CTRL, 32'h0);
        rdc(`REG_STATUS, st(1'b0, 1'b0, 1'b0));
        rdc(`REG_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        chk_out(1'b0, 100);
        done("reset");
        // manual switch with a random interrupt mask
        idle(300);
        apb(1'b0, `REG_IRQ_STATUS, 32'h0);
        mask = 3'($random(seed));
        apb(1'b1, `REG_IRQ_MASK, {29'h0, mask});
        rdc(`REG_IRQ_MASK, {29'h0, mask});
        apb(1'b1, `REG_CTRL, 32'h1);
        wait_sel(1'b1, 3000);
        rdc(`REG_STATUS, st(1'b1, 1'b0, 1'b0));
        chk({31'h0, irq}, {31'h0, mask[0]});
        rdc(`REG_IRQ_STATUS, 32'h1);
        rdc(`REG_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk_out(1'b1, 100);
        apb(1'b1, `REG_CTRL, 32'h0);
        idle(600);
        wait_sel(1'b1, 0);
        apb(1'b1, `REG_CTRL, 32'h1);
        wait_sel(1'b0, 3000);
        apb(1'b1, `REG_CTRL, 32'h0);
        done("manual");
        // request shorter than three slow input cycles
        p_half <= 200;
        b_half <= 200;
        idle(1000);
        apb(1'b1, `REG_CTRL, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h0);
        idle(2000);
        wait_sel(1'b0, 0);
        p_half <= 21 + ($random(seed) & 1);
        b_half <= 22 + ($random(seed) & 1);
        idle(1500);
        done("abort");
        // target input stalled, then resumes
        b_run <= 1'b0;
        idle(200);
        rdc(`REG_STATUS, st(1'b0, 1'b0, 1'b1));
        apb(1'b1, `REG_CTRL, 32'h1);
        idle(800);
        wait_sel(1'b0, 0);
        b_run <= 1'b1;
        wait_sel(1'b1, 3000);
        apb(1'b1, `REG_CTRL, 32'h0);
        done("target stalled");
        // current input stalled, manual request must wait
        b_run <= 1'b0;
        apb(1'b1, `REG_CTRL, 32'h1);
        idle(1500);
        wait_sel(1'b1, 0);
        b_run <= 1'b1;
        wait_sel(1'b0, 3000);
        apb(1'b1, `REG_CTRL, 32'h0);
        done("current stalled");
        // automatic switch on loss of the current input
        apb(1'b1, `REG_CTRL, 32'h2);
        p_run <= 1'b0;
        wait_sel(1'b1, 3000);
        rdc(`REG_STATUS, st(1'b1, 1'b1, 1'b0));
        p_run <= 1'b1;
        idle(300);
        rdc(`REG_STATUS, st(1'b1, 1'b0, 1'b0));
        done("automatic");
        // override: request switches, then blocks the automatic path
        apb(1'b1, `REG_CTRL, 32'h3);
        wait_sel(1'b0, 3000);
        p_run <= 1'b0;
        idle(1500);
        wait_sel(1'b0, 0);
        apb(1'b1, `REG_CTRL, 32'h2);
        wait_sel(1'b1, 3000);
        p_run <= 1'b1;
        idle(300);
        done("override");
        give_verdict();
    end
endmodule : tb_ref_clock_switchover

`default_nettype wire
